/* rtl/dpl_pkg.sv */
// constants, types and the colour-to-serial placement shared by the pixel map
package dpl_pkg;

    // widths of the double-pumped input and of one colour
    localparam int unsigned DPL_SAMPLE_W     = 12;
    localparam int unsigned DPL_COLOR_W      = 8;
    localparam int unsigned DPL_CHAN_W       = 8;

    // field positions inside the first-edge sample (lower half of the pixel)
    localparam int unsigned DPL_BLUE_LSB     = 0;
    localparam int unsigned DPL_GREEN_LO_LSB = 8;
    // field positions inside the second-edge sample (upper half of the pixel)
    localparam int unsigned DPL_GREEN_HI_LSB = 0;
    localparam int unsigned DPL_RED_LSB      = 4;
    localparam int unsigned DPL_GREEN_HALF_W = 4;

    // serial channel enables per port mode: a0..a3 only, or a0..a7
    localparam logic [7:0]  DPL_CHAN_SINGLE  = 8'h0F;
    localparam logic [7:0]  DPL_CHAN_DUAL    = 8'hFF;
    localparam logic [7:0]  DPL_CHAN_RESET   = 8'h00;

    // reset values
    localparam logic [11:0] DPL_SAMPLE_RESET = 12'h000;
    localparam logic [7:0]  DPL_COLOR_RESET  = 8'h00;

    // pairing phase of one input port
    typedef enum logic [0:0] {
        DPL_WAIT_FIRST  = 1'b0,  // expecting the first-edge sample
        DPL_WAIT_SECOND = 1'b1   // lower half held, expecting the second-edge sample
    } dpl_phase_t;

    // colour bits 0,1 go to serial bits 6,7; colour bits 2..7 go to serial bits 0..5
    function automatic logic [7:0] dpl_to_serial(input logic [7:0] color);
        return {color[1], color[0], color[7:2]};
    endfunction

endpackage : dpl_pkg

/* rtl/dpl_pair_capture.sv */
// pairs two edge samples of one input port into a serial-ordered 24-bit pixel
`timescale 1ns/100ps
module dpl_pair_capture
    import dpl_pkg::*;
(
    input  wire logic        clock,         // system clock
    input  wire logic        rst_n,         // asynchronous reset, active low
    input  wire logic        sample_valid,  // a sample is present this cycle
    input  wire logic        sample_first,  // sample belongs to the first capture edge
    input  wire logic [11:0] sample_data,   // twelve input lines
    input  wire logic        port_enable,   // low forces the completed pixel to zero
    output logic      [7:0]  red_ser,       // red in serial bit order
    output logic      [7:0]  green_ser,     // green in serial bit order
    output logic      [7:0]  blue_ser,      // blue in serial bit order
    output logic             pixel_valid    // one-cycle pulse, new pixel on the outputs
);

    // whole state of the port
    typedef struct packed {
        dpl_phase_t  phase;  // pairing phase
        logic [11:0] low;    // first-edge sample held
        logic [7:0]  red;    // red output register
        logic [7:0]  green;  // green output register
        logic [7:0]  blue;   // blue output register
        logic        valid;  // pixel strobe register
    } dpl_pair_state_t;

    dpl_pair_state_t s_q;  // registered state
    dpl_pair_state_t s_d;  // next state

    logic [7:0] red_c;    // red colour of the pixel being completed
    logic [7:0] green_c;  // green colour of the pixel being completed
    logic [7:0] blue_c;   // blue colour of the pixel being completed

    // next-state logic: hold the lower half, complete on the upper half
    always_comb begin
        s_d       = s_q;
        s_d.valid = 1'b0;
        // blue from first-edge lines 0..7 [R05]
        blue_c    = s_q.low[DPL_BLUE_LSB +: DPL_COLOR_W];
        // green 0..3 from first-edge lines 8..11, green 4..7 from second-edge 0..3 [R06] [R07]
        green_c   = {sample_data[DPL_GREEN_HI_LSB +: DPL_GREEN_HALF_W],
                     s_q.low[DPL_GREEN_LO_LSB +: DPL_GREEN_HALF_W]};
        // red from second-edge lines 4..11 [R08]
        red_c     = sample_data[DPL_RED_LSB +: DPL_COLOR_W];
        if (sample_valid) begin
            if (sample_first) begin
                // first edge takes the lower half, a repeat restarts the pixel [R11]
                s_d.low   = sample_data;
                s_d.phase = DPL_WAIT_SECOND;
            end else if (s_q.phase == DPL_WAIT_SECOND) begin
                // second edge completes the pixel as one 24-bit word [R13]
                s_d.red   = port_enable ? dpl_to_serial(red_c) : DPL_COLOR_RESET;   // [R04]
                s_d.green = port_enable ? dpl_to_serial(green_c) : DPL_COLOR_RESET; // [R04]
                s_d.blue  = port_enable ? dpl_to_serial(blue_c) : DPL_COLOR_RESET;  // [R04]
                s_d.valid = 1'b1;
                s_d.phase = DPL_WAIT_FIRST;
            end
            // a second-edge sample with no lower half held is dropped
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{phase: DPL_WAIT_FIRST, low: DPL_SAMPLE_RESET, red: DPL_COLOR_RESET,
                     green: DPL_COLOR_RESET, blue: DPL_COLOR_RESET, valid: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the registers, named by colour and serial bit [R03]
    assign red_ser     = s_q.red;
    assign green_ser   = s_q.green;
    assign blue_ser    = s_q.blue;
    assign pixel_valid = s_q.valid;

endmodule // dpl_pair_capture

/* rtl/dpl_pixel_map.sv */
// double-pumped pixel input mapped onto serial-ordered colour bits, one or two ports
`timescale 1ns/100ps

// Summary of operation
// (R01) single port: only channels a0..a3 carry data
// (R02) dual port: all channels a0..a7 driven
// (R03) bits named by colour, pixel, serial number
// (R04) serial bits 6,7 carry colour bits 0,1
// (R05) first edge lines 0..7 give blue
// (R06) first edge lines 8..11 give green 0..3
// (R07) second edge lines 0..3 give green 4..7
// (R08) second edge lines 4..11 give red
// (R09) 18-bit receiver uses serial bits 0..5 only
// (R10) primary port carries odd pixel, index one
// (R11) first edge lower half, second edge upper
// (R12) secondary port carries even pixel, index two
// (R13) two edge samples pair into one pixel
module dpl_pixel_map
    import dpl_pkg::*;
(
    input  wire logic        clock,                  // 40 MHz system clock
    input  wire logic        rst_n,                  // asynchronous reset, active low
    input  wire logic        dual_port_select,       // high selects two 12-bit input ports
    input  wire logic        balance_coding_select,  // balance setting handed to serializer
    input  wire logic        sample_valid,           // samples present on both ports
    input  wire logic        sample_first,           // samples are from the first capture edge
    input  wire logic [11:0] primary_data,           // primary port lines, odd pixel
    input  wire logic [11:0] secondary_data,         // secondary port lines, even pixel
    output logic      [7:0]  pix1_red_ser,           // odd pixel red, serial order
    output logic      [7:0]  pix1_green_ser,         // odd pixel green, serial order
    output logic      [7:0]  pix1_blue_ser,          // odd pixel blue, serial order
    output logic      [7:0]  pix2_red_ser,           // even pixel red, serial order
    output logic      [7:0]  pix2_green_ser,         // even pixel green, serial order
    output logic      [7:0]  pix2_blue_ser,          // even pixel blue, serial order
    output logic             pixel_valid,            // one-cycle pulse per completed pixel
    output logic      [7:0]  channel_enable,         // serial data channels a7..a0 in use
    output logic             balance_out             // registered balance setting
);

    // whole state of the top: mode, balance, channel enables and check helpers
    typedef struct packed {
        logic        dual;     // port mode taken with the first-edge sample
        logic        balance;  // balance setting register
        logic [7:0]  chan;     // channel enable register
        logic [11:0] lo1;      // last first-edge primary sample
        logic [11:0] lo2;      // last first-edge secondary sample
        logic [11:0] hi1;      // primary lines one cycle ago
        logic [11:0] hi2;      // secondary lines one cycle ago
    } dpl_top_state_t;

    dpl_top_state_t s_q;  // registered state
    dpl_top_state_t s_d;  // next state

    logic pix2_valid;  // secondary strobe, checked against the primary one

    // next-state logic
    always_comb begin
        s_d         = s_q;
        // balance only passed on, its coding belongs to the serializer
        s_d.balance = balance_coding_select;
        // mode is sampled with the lower half so a pixel never mixes modes
        if (sample_valid && sample_first) begin
            s_d.dual = dual_port_select;
            s_d.lo1  = primary_data;
            s_d.lo2  = secondary_data;
        end
        // channel group follows the port mode [R01] [R02]
        s_d.chan = s_q.dual ? DPL_CHAN_DUAL : DPL_CHAN_SINGLE;
        // lines of the last cycle, the upper half when a pixel completes
        s_d.hi1  = primary_data;
        s_d.hi2  = secondary_data;
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // single mode, no lanes in use, check helpers cleared
            s_q <= '{dual: 1'b0, balance: 1'b0, chan: DPL_CHAN_RESET,
                     lo1: DPL_SAMPLE_RESET, lo2: DPL_SAMPLE_RESET,
                     hi1: DPL_SAMPLE_RESET, hi2: DPL_SAMPLE_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // each port pairs its own two halves independently
    // primary port builds the odd pixel, index one [R10]
    dpl_pair_capture u_primary (
        .clock        (clock),
        .rst_n        (rst_n),
        .sample_valid (sample_valid),
        .sample_first (sample_first),
        .sample_data  (primary_data),
        .port_enable  (1'b1),
        .red_ser      (pix1_red_ser),
        .green_ser    (pix1_green_ser),
        .blue_ser     (pix1_blue_ser),
        .pixel_valid  (pixel_valid)
    );

    // secondary port builds the even pixel, zero in single mode [R12] [R01]
    dpl_pair_capture u_secondary (
        .clock        (clock),
        .rst_n        (rst_n),
        .sample_valid (sample_valid),
        .sample_first (sample_first),
        .sample_data  (secondary_data),
        .port_enable  (s_q.dual),
        .red_ser      (pix2_red_ser),
        .green_ser    (pix2_green_ser),
        .blue_ser     (pix2_blue_ser),
        .pixel_valid  (pix2_valid)
    );

    // registered outputs of the top
    assign channel_enable = s_q.chan;
    assign balance_out    = s_q.balance;

    // checks on what the block drives, sampled on the rising clock edge

    // single mode leaves the even pixel at zero
    a_single_even_idle: assert property (@(posedge clock) disable iff (!rst_n)  // [R01]
        (pixel_valid && !s_q.dual) |->
        ({pix2_red_ser, pix2_green_ser, pix2_blue_ser} == 24'h000000))
        else $error("even pixel not zero in single port mode");

    // single mode enables only the low channel group
    a_chan_single: assert property (@(posedge clock) disable iff (!rst_n)  // [R01]
        !s_q.dual |=> (channel_enable == 8'h0F))
        else $error("channel enables wrong in single port mode");

    // dual mode enables all channels
    a_chan_dual: assert property (@(posedge clock) disable iff (!rst_n)  // [R02]
        s_q.dual |=> (channel_enable == 8'hFF))
        else $error("channel enables wrong in dual port mode");

    // serial order of blue from the first edge, odd pixel
    a_blue_order: assert property (@(posedge clock) disable iff (!rst_n)  // [R04] [R05] [R10]
        pixel_valid |-> (pix1_blue_ser[7:6] == {s_q.lo1[1], s_q.lo1[0]}) &&
                        (pix1_blue_ser[5:0] == s_q.lo1[7:2]))
        else $error("odd pixel blue placement wrong");

    // green low half from first edge lines 8..11
    a_green_low: assert property (@(posedge clock) disable iff (!rst_n)  // [R06]
        pixel_valid |-> (pix1_green_ser[7:6] == {s_q.lo1[9], s_q.lo1[8]}) &&
                        (pix1_green_ser[1:0] == s_q.lo1[11:10]))
        else $error("odd pixel green low half wrong");

    // green high half from second edge lines 0..3
    a_green_high: assert property (@(posedge clock) disable iff (!rst_n)  // [R07] [R11]
        pixel_valid |-> (pix1_green_ser[5:2] == s_q.hi1[3:0]))
        else $error("odd pixel green high half wrong");

    // red from second edge lines 4..11
    a_red_order: assert property (@(posedge clock) disable iff (!rst_n)  // [R08]
        pixel_valid |-> (pix1_red_ser[7:6] == {s_q.hi1[5], s_q.hi1[4]}) &&
                        (pix1_red_ser[5:0] == s_q.hi1[11:6]))
        else $error("odd pixel red placement wrong");

    // even pixel uses the same placement from the secondary port
    a_even_map: assert property (@(posedge clock) disable iff (!rst_n)  // [R12]
        (pixel_valid && s_q.dual) |->
        (pix2_blue_ser == {s_q.lo2[1], s_q.lo2[0], s_q.lo2[7:2]}) &&
        (pix2_red_ser == {s_q.hi2[5], s_q.hi2[4], s_q.hi2[11:6]}) &&
        (pix2_green_ser == {s_q.lo2[9], s_q.lo2[8], s_q.hi2[3:0], s_q.lo2[11:10]}))
        else $error("even pixel placement wrong");

    // first then second edge sample gives a pixel on the next cycle
    a_pair_done: assert property (@(posedge clock) disable iff (!rst_n)  // [R13]
        (sample_valid && sample_first) ##1 (sample_valid && !sample_first) |=>
        pixel_valid)
        else $error("pixel not completed after edge pair");

    // no pixel without a second-edge sample just before
    a_pair_cause: assert property (@(posedge clock) disable iff (!rst_n)  // [R13]
        pixel_valid |-> $past(sample_valid) && !$past(sample_first))
        else $error("pixel strobe without second edge sample");

    // a pixel strobe is never two cycles long
    a_pulse_once: assert property (@(posedge clock) disable iff (!rst_n)  // [R13]
        pixel_valid |=> !pixel_valid)
        else $error("pixel strobe held too long");

    // both ports finish their pixel on the same edge
    a_strobe_match: assert property (@(posedge clock) disable iff (!rst_n)  // [R12] [R13]
        pix2_valid == pixel_valid)
        else $error("port pixel strobes out of step");

    // a new pixel leaves on the lane group of the mode it was taken in
    a_pixel_lanes: assert property (@(posedge clock) disable iff (!rst_n)  // [R01] [R02]
        pixel_valid |-> (channel_enable == (s_q.dual ? 8'hFF : 8'h0F)))
        else $error("pixel presented on wrong lane group");

    // colours stay put between completed pixels
    a_pix_hold: assert property (@(posedge clock) disable iff (!rst_n)  // [R13]
        !pixel_valid |-> $stable({pix1_red_ser, pix1_green_ser, pix1_blue_ser,
                                  pix2_red_ser, pix2_green_ser, pix2_blue_ser}))
        else $error("pixel colours changed without a strobe");

    // port mode taken with the lower half of a pixel
    a_mode_follow: assert property (@(posedge clock) disable iff (!rst_n)  // [R11]
        (sample_valid && sample_first) |=> (s_q.dual == $past(dual_port_select)))
        else $error("port mode not taken with the lower half");

    // mode ignored between halves, so a pixel never mixes modes
    a_mode_hold: assert property (@(posedge clock) disable iff (!rst_n)  // [R11]
        !(sample_valid && sample_first) |=> $stable(s_q.dual))
        else $error("port mode changed without a lower half");

    // a lower half alone never completes a pixel
    a_first_quiet: assert property (@(posedge clock) disable iff (!rst_n)  // [R11]
        (sample_valid && sample_first) |=> !pixel_valid)
        else $error("pixel strobe after a lower half");

    // an upper half right after another upper half finds no lower half held
    a_lone_drop: assert property (@(posedge clock) disable iff (!rst_n)  // [R13]
        (sample_valid && !sample_first) ##1 (sample_valid && !sample_first) |=>
        !pixel_valid)
        else $error("lone upper half completed a pixel");

    // balance setting passed on one cycle later
    a_balance_pass: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> (balance_out == $past(balance_coding_select)))
        else $error("balance setting not passed through");

endmodule // dpl_pixel_map

/* verification/dpl_panel_rx.sv */
// flat panel receiver model rebuilding colours from serial-ordered lanes
`timescale 1ns/100ps
module dpl_panel_rx
    import dpl_pkg::*;
(
    input  wire logic [7:0]  pix1_red_ser,    // odd pixel red lanes
    input  wire logic [7:0]  pix1_green_ser,  // odd pixel green lanes
    input  wire logic [7:0]  pix1_blue_ser,   // odd pixel blue lanes
    input  wire logic [7:0]  pix2_red_ser,    // even pixel red lanes
    input  wire logic [7:0]  pix2_green_ser,  // even pixel green lanes
    input  wire logic [7:0]  pix2_blue_ser,   // even pixel blue lanes
    input  wire logic [7:0]  channel_enable,  // lanes in use
    output logic      [23:0] rx_pix1,         // odd pixel as red, green, blue
    output logic      [23:0] rx_pix2,         // even pixel as red, green, blue
    output logic      [17:0] rx18_pix1        // odd pixel seen by an 18-bit panel
);
    // serial bits 6,7 back to colour bits 0,1, bits 0..5 back to 2..7
    function automatic logic [7:0] unser(input logic [7:0] s);
        return {s[5:0], s[7], s[6]};
    endfunction

    // decode what a panel sees on the lanes
    always_comb begin
        rx_pix1 = {unser(pix1_red_ser), unser(pix1_green_ser), unser(pix1_blue_ser)};
        // upper lane group idle: no even pixel reaches the panel
        if (channel_enable[7:4] == 4'hF) begin
            rx_pix2 = {unser(pix2_red_ser), unser(pix2_green_ser), unser(pix2_blue_ser)};
        end else begin
            rx_pix2 = 24'h000000;
        end
        // narrow panel takes serial bits 0..5 only
        rx18_pix1 = {pix1_red_ser[5:0], pix1_green_ser[5:0], pix1_blue_ser[5:0]};
    end
endmodule // dpl_panel_rx

/* verification/tb.sv */
// self-checking bench for the double-pumped pixel map
`timescale 1ns/100ps
module tb;
    import dpl_pkg::*;
    logic        clock, rst_n, dual_port_select, balance_coding_select;
    logic        sample_valid, sample_first, pixel_valid, balance_out;
    logic [11:0] primary_data, secondary_data;
    logic [7:0]  r1, g1, b1, r2, g2, b2, channel_enable;
    logic [23:0] rx_pix1, rx_pix2;
    logic [17:0] rx18_pix1;
    int          n_errors, tests_run, cycles;

    dpl_pixel_map u_dpl_pixel_map (.clock(clock), .rst_n(rst_n),
        .dual_port_select(dual_port_select), .balance_coding_select(balance_coding_select),
        .sample_valid(sample_valid), .sample_first(sample_first),
        .primary_data(primary_data), .secondary_data(secondary_data),
        .pix1_red_ser(r1), .pix1_green_ser(g1), .pix1_blue_ser(b1),
        .pix2_red_ser(r2), .pix2_green_ser(g2), .pix2_blue_ser(b2),
        .pixel_valid(pixel_valid), .channel_enable(channel_enable), .balance_out(balance_out));
    dpl_panel_rx u_dpl_panel_rx (.pix1_red_ser(r1), .pix1_green_ser(g1), .pix1_blue_ser(b1),
        .pix2_red_ser(r2), .pix2_green_ser(g2), .pix2_blue_ser(b2),
        .channel_enable(channel_enable), .rx_pix1(rx_pix1), .rx_pix2(rx_pix2),
        .rx18_pix1(rx18_pix1));

    // free-running 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            $display("FAIL %0t timeout", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // word compare
    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // flag compare
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // one sample, then the edge that takes it
    task automatic put(input logic v, input logic f, input logic [11:0] p, input logic [11:0] s);
        sample_valid = v;
        sample_first = f;
        primary_data = p;
        secondary_data = s;
        @(posedge clock);
        #1;
    endtask

    // full pixel on both ports, judged right after the answer edge
    task automatic pixel(input logic m, input logic [11:0] pl, input logic [11:0] ph,
                         input logic [11:0] sl, input logic [11:0] sh);
        dual_port_select = m;
        put(1'b1, 1'b1, pl, sl);
        chk_bit(pixel_valid, 1'b0, "pulse early");
        put(1'b1, 1'b0, ph, sh);
        chk_bit(pixel_valid, 1'b1, "pulse");
        chk_word(rx_pix1, {ph, pl}, "odd pixel");
        chk_word(rx_pix2, m ? {sh, sl} : 24'h000000, "even pixel");
        if (!m) begin
            chk_word({r2, g2, b2}, 24'h000000, "even idle");
        end
        chk_word({16'h0000, channel_enable}, m ? 24'h0000FF : 24'h00000F, "lanes");
    endtask

    // lone upper half dropped, newer lower half wins, mode held across halves
    task automatic t_refuse();
        put(1'b1, 1'b0, 12'hFFF, 12'hFFF);
        put(1'b1, 1'b0, 12'hEEE, 12'hEEE);
        chk_bit(pixel_valid, 1'b0, "two upper halves");
        put(1'b0, 1'b0, 12'h000, 12'h000);
        chk_bit(pixel_valid, 1'b0, "lone upper half");
        dual_port_select = 1'b0;
        put(1'b1, 1'b1, 12'h111, 12'h222);
        put(1'b0, 1'b1, 12'h999, 12'h999);
        put(1'b1, 1'b1, 12'hC3A, 12'h5E7);
        dual_port_select = 1'b1;
        put(1'b0, 1'b0, 12'h000, 12'h000);
        put(1'b1, 1'b0, 12'h6B2, 12'h1D4);
        chk_bit(pixel_valid, 1'b1, "gap pulse");
        chk_word(rx_pix1, 24'h6B2C3A, "replaced half");
        chk_word(rx_pix2, 24'h000000, "mode kept");
        chk_word({r2, g2, b2}, 24'h000000, "even zeroed");
        chk_word({16'h0000, channel_enable}, 24'h00000F, "lanes kept");
    endtask

    // main sequence
    initial begin
        {rst_n, dual_port_select, balance_coding_select, sample_valid, sample_first} = 5'h00;
        primary_data = 12'h000;
        secondary_data = 12'h000;
        repeat (8) @(posedge clock);
        #1;
        chk_word({15'h0000, pixel_valid, channel_enable}, 24'h000000, "reset outputs");
        rst_n = 1'b1;
        @(posedge clock);
        #1;
        chk_word({16'h0000, channel_enable}, 24'h00000F, "default lanes");
        // single port, serial placement looked at directly
        pixel(1'b0, 12'hA5C, 12'h3F1, 12'h777, 12'h888);
        chk_word({r1, g1, b1}, {8'hCF, 8'h86, 8'h17}, "serial order");
        chk_word({6'h00, rx18_pix1}, {6'h00, 6'h0F, 6'h06, 6'h17}, "narrow panel");
        // walking lines, back to back, dual port
        for (int i = 0; i < 12; i++) begin
            pixel(1'b1, 12'h001 << i, 12'h800 >> i, 12'hFFF ^ (12'h001 << i), 12'h001 << i);
        end
        put(1'b0, 1'b0, 12'h000, 12'h000);
        chk_bit(pixel_valid, 1'b0, "pulse width");
        t_refuse();
        // balance setting passes through one cycle later
        balance_coding_select = 1'b1;
        put(1'b0, 1'b0, 12'h000, 12'h000);
        chk_bit(balance_out, 1'b1, "balance set");
        balance_coding_select = 1'b0;
        put(1'b0, 1'b0, 12'h000, 12'h000);
        chk_bit(balance_out, 1'b0, "balance clear");
        // reset in mid-run clears lanes and colours, held over one edge
        rst_n = 1'b0;
        #5;
        chk_word({16'h0000, channel_enable}, 24'h000000, "mid reset");
        chk_word({r1, g1, b1}, 24'h000000, "mid reset odd");
        chk_word({r2, g2, b2}, 24'h000000, "mid reset even");
        @(posedge clock);
        #1;
        rst_n = 1'b1;
        pixel(1'b1, 12'h0F0, 12'hF0F, 12'h123, 12'h456);
        test_done();
    end
endmodule // tb
